// ### fpdm_pkg.sv
package fpdm_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int STANDBY_RECOVERY_MS = 500;
  // longest time, so integer division rounds down
  localparam int STANDBY_RECOVERY_CYC = (STANDBY_RECOVERY_MS * 1000000) / CLK_PERIOD_NS;
  localparam int STBY_CNT_W = 24;

  // cyclic frame
  localparam int FRAME_BYTES = 15;
  localparam int FRAME_BITS = FRAME_BYTES * 8;
  localparam int FRAME_CNT_W = $clog2(FRAME_BYTES + 1);

  // register byte offsets
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_STATE = 8'h04;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_CLEAR = 8'h0C;
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h10;
  localparam logic [7:0] REG_VELOCITY = 8'h14;
  localparam logic [7:0] REG_LENGTH = 8'h18;
  localparam logic [7:0] REG_RATE_TEMP = 8'h1C;
  localparam logic [7:0] REG_CONTROL_BYTE = 8'h20;
  localparam logic [7:0] REG_NET_ADDR = 8'h24;
  localparam logic [7:0] REG_DEVICE_ID = 8'h28;

  // config register fields
  localparam int CFG_STANDBY_SELECT = 0;
  localparam int CFG_OUTPUT_ENABLE = 1;
  localparam int CFG_SYNC_SELECT = 2;
  localparam int CFG_STATIC_ADDR = 3;
  localparam int CFG_W = 4;
  localparam logic [CFG_W-1:0] CFG_RESET = 4'h2;

  // status byte fields
  localparam int ST_ERROR = 0;
  localparam int ST_SIGNAL = 1;
  localparam int ST_VEL_NEG = 2;
  localparam int ST_LEN_NEG = 3;

  // control byte fields
  localparam int CB_STANDBY_A = 0;
  localparam int CB_DIRECTION = 1;
  localparam int CB_STANDBY_TRIG_B = 2;
  localparam int CB_TRIG_A = 3;
  localparam int CB_CLEAR = 4;
  localparam int CB_SET_LO = 5;
  localparam int CB_SET_HI = 6;
  localparam int CB_RESTORE = 7;

  // interrupt status bits
  localparam int IRQ_FRAME = 0;
  localparam int IRQ_OVERRUN = 1;
  localparam int IRQ_CONTROL = 2;
  localparam int IRQ_CLEAR = 3;
  localparam int IRQ_RESTORE = 4;
  localparam int IRQ_READY = 5;
  localparam int IRQ_W = 6;

  // network address
  localparam logic [31:0] FALLBACK_ADDR = 32'hC0A80033;
  // arbitrary value, identifies this block only
  localparam logic [31:0] DEVICE_ID = 32'h00F0_D0A1;

  typedef struct packed {
    logic signed [32:0] velocity;  // 0.00001 m/s per count
    logic [15:0] rate;             // 0.1 % per count
    logic signed [47:0] length;    // 0.0001 m per count
    logic [7:0] err_num;
    logic err_flag;
    logic sig_flag;
    logic [7:0] temp;
  } fpdm_sample_t;

  typedef struct packed {
    logic standby;
    logic direction;
    logic trig_a;
    logic trig_b;
    logic clear_errors;
    logic restore;
    logic [1:0] restore_set;
  } fpdm_action_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } fpdm_tx_t;

  function automatic logic [47:0] fpdm_mag(input logic signed [47:0] v);
    fpdm_mag = v[47] ? 48'(-v) : 48'(v);
  endfunction

endpackage

// ### fpdm_serializer.sv
`timescale 1ns/1ps
`default_nettype none
module fpdm_serializer
  import fpdm_pkg::*;
(
  input wire logic pclk,                   // system clock
  input wire logic presetn,                // async reset, active low
  input wire logic clk_en,                 // freezes state while low
  input wire logic load,                   // take a new frame
  input wire logic [FRAME_BITS-1:0] frame, // msb goes out first
  output logic busy,                       // frame in flight
  output logic tx_valid,                   // byte valid
  input wire logic tx_ready,               // sink takes byte
  output fpdm_tx_t tx                      // byte and end mark
);

  typedef struct packed {
    logic [FRAME_BITS-1:0] shreg;
    logic [FRAME_CNT_W-1:0] left;
  } fpdm_ser_state_t;

  fpdm_ser_state_t s_q;
  fpdm_ser_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (s_q.left != '0) begin
      if (tx_ready) begin
        s_d.shreg = {s_q.shreg[FRAME_BITS-9:0], 8'h00};
        s_d.left = s_q.left - 1'b1;
      end
    end else if (load) begin
      s_d.shreg = frame;
      s_d.left = FRAME_CNT_W'(FRAME_BYTES);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign busy = (s_q.left != '0);
  assign tx_valid = busy;
  assign tx.data = s_q.shreg[FRAME_BITS-1:FRAME_BITS-8];
  assign tx.last = (s_q.left == FRAME_CNT_W'(1));

endmodule // fpdm_serializer
`default_nettype wire

// ### fpdm_mapper.sv
// How it works
// - frame: counter, velocity, rate, length, error, status, temperature
// - velocity, length, rate as scaled integer counts
// - magnitudes only; signs go to status
// - sent length wraps at 32 bits
// - status: error, signal, speed sign, length sign
// - standby select set: bit 0 means standby
// - bit 1 drives counting direction
// - bit 3 trigger one, bit 2 trigger two when standby select set
// - bit 4 rising edge clears errors once
// - bits 6:5 pick set, bit 7 restores
// - standby select clear: bit 2 means standby
// - ready again at most 500 ms after standby
// - frames continuous or trigger synchronous
// - status values readable for the web page
// - dhcp address, else fixed fallback address
`timescale 1ns/1ps
`default_nettype none
module fpdm_mapper
  import fpdm_pkg::*;
#(
  parameter int STANDBY_CYC = STANDBY_RECOVERY_CYC
) (
  input wire logic pclk,               // system clock, 25 MHz
  input wire logic presetn,            // async reset, active low
  input wire logic clk_en,             // freezes all state while low
  input wire logic psel,               // apb select
  input wire logic penable,            // apb access phase
  input wire logic pwrite,             // apb direction
  input wire logic [7:0] paddr,        // apb byte address
  input wire logic [31:0] pwdata,      // apb write data
  output logic [31:0] prdata,          // apb read data
  output logic pready,                 // apb ready
  output logic pslverr,                // apb error on unmapped address
  output logic irq,                    // level interrupt
  input wire logic sample_valid,       // new measurement from the sensor
  input wire fpdm_sample_t sample,     // measurement values
  input wire logic ctrl_valid,         // control byte update from scanner
  input wire logic [7:0] ctrl_byte,    // scanner control byte
  output fpdm_action_t action,         // decoded sensor actions
  output logic meas_ready,             // sensor ready to measure
  input wire logic dhcp_bound,         // dhcp lease obtained
  input wire logic dhcp_timeout,       // no dhcp server answered
  input wire logic [31:0] dhcp_addr,   // leased address
  output logic [31:0] net_addr,        // address in use
  output logic tx_valid,               // frame byte valid
  input wire logic tx_ready,           // network side takes the byte
  output fpdm_tx_t tx                  // frame byte and end mark
);

  typedef struct packed {
    logic [CFG_W-1:0] cfg;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_en;
    logic [7:0] cb;
    fpdm_action_t act;
    logic [STBY_CNT_W-1:0] stby_cnt;
    logic ready;
    logic [31:0] rdata;
    fpdm_sample_t smp;
    logic smp_ok;
    logic [15:0] fcnt;
    logic trig_prev;
    logic [31:0] addr;
    logic irq;
  } fpdm_state_t;

  localparam logic [STBY_CNT_W-1:0] STBY_LAST = STBY_CNT_W'(STANDBY_CYC - 1);

  fpdm_state_t s_q;
  fpdm_state_t s_d;

  logic ser_busy;
  logic ser_load;
  logic [FRAME_BITS-1:0] frame;
  logic [47:0] vel_mag;
  logic [47:0] len_mag;
  logic [7:0] status_byte;
  logic [7:0] cb_rise;
  logic standby_now;
  logic trig_now;
  logic launch;
  logic wr_acc;
  logic rd_setup;

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == REG_CONFIG) || (a == REG_STATE) || (a == REG_IRQ_STATUS) ||
                  (a == REG_IRQ_CLEAR) || (a == REG_IRQ_ENABLE) || (a == REG_VELOCITY) ||
                  (a == REG_LENGTH) || (a == REG_RATE_TEMP) || (a == REG_CONTROL_BYTE) ||
                  (a == REG_NET_ADDR) || (a == REG_DEVICE_ID);
  endfunction

  function automatic logic [7:0] make_status(input fpdm_sample_t m);
    logic [7:0] b;
    b = 8'h00;
    b[ST_ERROR] = m.err_flag;
    b[ST_SIGNAL] = m.sig_flag;
    b[ST_VEL_NEG] = m.velocity[32];
    b[ST_LEN_NEG] = m.length[47];
    make_status = b;
  endfunction

  // frame built from the latched sample
  assign vel_mag = fpdm_mag(48'(s_q.smp.velocity));
  assign len_mag = fpdm_mag(s_q.smp.length);
  assign status_byte = make_status(s_q.smp);
  // low 32 bits only; the accumulator upstream keeps its full 48 bits
  assign frame = {s_q.fcnt, vel_mag[31:0], s_q.smp.rate, len_mag[31:0],
                  s_q.smp.err_num, status_byte, s_q.smp.temp};

  // control byte decode, latest value once per capture
  assign cb_rise = ctrl_byte & ~s_q.cb;
  assign standby_now = s_q.cfg[CFG_STANDBY_SELECT] ? s_q.cb[CB_STANDBY_A]
                                                   : s_q.cb[CB_STANDBY_TRIG_B];
  assign trig_now = s_q.act.trig_a | s_q.act.trig_b;

  // continuous: every sample not replaced by a newer one while a frame is in flight; synchronous: rising trigger sends the latest sample
  always_comb begin
    launch = 1'b0;
    if (s_q.cfg[CFG_OUTPUT_ENABLE] && s_q.smp_ok) begin
      if (s_q.cfg[CFG_SYNC_SELECT]) begin
        launch = trig_now && !s_q.trig_prev;
      end else begin
        launch = 1'b1;
      end
    end
  end
  assign ser_load = launch && !ser_busy;

  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;

  always_comb begin
    s_d = s_q;
    s_d.act.clear_errors = 1'b0;
    s_d.act.restore = 1'b0;
    // clear applied before the events below, so a same-cycle event sets the bit again
    if (wr_acc && (paddr == REG_IRQ_CLEAR)) begin
      s_d.irq_st = s_q.irq_st & ~pwdata[IRQ_W-1:0];
    end

    // sample capture; smp_ok drops once a continuous frame is taken
    if (sample_valid) begin
      s_d.smp = sample;
      s_d.smp_ok = 1'b1;
    end else if (ser_load && !s_q.cfg[CFG_SYNC_SELECT]) begin
      s_d.smp_ok = 1'b0;
    end
    s_d.trig_prev = trig_now;
    if (ser_load) begin
      s_d.fcnt = s_q.fcnt + 16'h0001;
      s_d.irq_st[IRQ_FRAME] = 1'b1;
    end
    // a waiting sample that could not start while the last frame is in flight is dropped when a new sample arrives
    if (launch && ser_busy && !s_q.cfg[CFG_SYNC_SELECT] && sample_valid) begin
      s_d.irq_st[IRQ_OVERRUN] = 1'b1;
    end

    // control byte
    if (ctrl_valid) begin
      s_d.cb = ctrl_byte;
      if (ctrl_byte != s_q.cb) begin
        s_d.irq_st[IRQ_CONTROL] = 1'b1;
      end
      if (cb_rise[CB_CLEAR]) begin
        s_d.act.clear_errors = 1'b1;
        s_d.irq_st[IRQ_CLEAR] = 1'b1;
      end
      // edge only, so a held bit 7 restores once
      if (cb_rise[CB_RESTORE]) begin
        s_d.act.restore = 1'b1;
        s_d.act.restore_set = ctrl_byte[CB_SET_HI:CB_SET_LO];
        s_d.irq_st[IRQ_RESTORE] = 1'b1;
      end
    end
    s_d.act.direction = s_q.cb[CB_DIRECTION];
    s_d.act.trig_a = s_q.cb[CB_TRIG_A];
    s_d.act.trig_b = s_q.cfg[CFG_STANDBY_SELECT] && s_q.cb[CB_STANDBY_TRIG_B];
    s_d.act.standby = standby_now;

    // recovery after standby
    if (s_q.act.standby) begin
      s_d.ready = 1'b0;
      s_d.stby_cnt = '0;
    end else if (!s_q.ready) begin
      if (s_q.stby_cnt >= STBY_LAST) begin
        s_d.ready = 1'b1;
        s_d.irq_st[IRQ_READY] = 1'b1;
      end else begin
        s_d.stby_cnt = s_q.stby_cnt + 1'b1;
      end
    end

    // network address
    if (s_q.cfg[CFG_STATIC_ADDR]) begin
      s_d.addr = FALLBACK_ADDR;
    end else if (dhcp_bound) begin
      s_d.addr = dhcp_addr;
    end else if (dhcp_timeout) begin
      s_d.addr = FALLBACK_ADDR;
    end

    // register writes; a clear loses against a same-cycle set
    if (wr_acc) begin
      unique case (paddr)
        REG_CONFIG: begin
          s_d.cfg = pwdata[CFG_W-1:0];
        end
        REG_IRQ_ENABLE: begin
          s_d.irq_en = pwdata[IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // read data prepared in the setup phase, stable in the access phase
    if (rd_setup) begin
      unique case (paddr)
        REG_CONFIG: s_d.rdata = 32'(s_q.cfg);
        REG_STATE: s_d.rdata = {22'h000000, s_q.act.standby, s_q.ready, status_byte};
        REG_IRQ_STATUS: s_d.rdata = 32'(s_q.irq_st);
        REG_IRQ_ENABLE: s_d.rdata = 32'(s_q.irq_en);
        REG_VELOCITY: s_d.rdata = vel_mag[31:0];
        REG_LENGTH: s_d.rdata = len_mag[31:0];
        REG_RATE_TEMP: s_d.rdata = {s_q.smp.err_num, s_q.smp.temp, s_q.smp.rate};
        REG_CONTROL_BYTE: s_d.rdata = {24'h000000, s_q.cb};
        REG_NET_ADDR: s_d.rdata = s_q.addr;
        REG_DEVICE_ID: s_d.rdata = DEVICE_ID;
        default: s_d.rdata = 32'h00000000;
      endcase
    end

    s_d.irq = |(s_d.irq_st & s_d.irq_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.cfg <= CFG_RESET;
      s_q.ready <= 1'b1;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  fpdm_serializer u_ser (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .load(ser_load),
    .frame(frame),
    .busy(ser_busy),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready),
    .tx(tx)
  );

  assign prdata = s_q.rdata;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !addr_mapped(paddr);
  assign irq = s_q.irq;
  assign action = s_q.act;
  assign meas_ready = s_q.ready;
  assign net_addr = s_q.addr;

endmodule // fpdm_mapper
`default_nettype wire

// ### fpdm_checker.sv
`timescale 1ns/1ps
`default_nettype none
module fpdm_checker
  import fpdm_pkg::*;
#(
  parameter int STANDBY_CYC = 20
) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic clk_en, // run
  input wire logic ctrl_valid, // byte strobe
  input wire logic [7:0] ctrl_byte, // control byte
  input wire fpdm_action_t action, // actions
  input wire logic meas_ready, // ready
  input wire logic dhcp_bound, // lease
  input wire logic dhcp_timeout, // no server
  input wire logic [31:0] net_addr, // address
  input wire logic tx_valid, // byte valid
  input wire logic tx_ready, // byte taken
  input wire fpdm_tx_t tx // byte
);
  localparam int RDY_MAX = STANDBY_CYC + 3;
  logic [7:0] cb_q;
  logic [3:0] bcnt_q;
  default clocking @(posedge pclk); endclocking
  // frozen cycles would shift every latency
  default disable iff (!presetn || !clk_en);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cb_q <= 8'h00;
      bcnt_q <= 4'h0;
    end else if (clk_en) begin
      if (ctrl_valid) cb_q <= ctrl_byte;
      if (tx_valid && tx_ready) bcnt_q <= tx.last ? 4'h0 : bcnt_q + 4'h1;
    end
  end
  property p_dir; ctrl_valid |-> ##2 action.direction == $past(ctrl_byte[CB_DIRECTION], 2); endproperty
  a_dir: assert property (p_dir) else $error("direction wrong");
  property p_trig; ctrl_valid |-> ##2 action.trig_a == $past(ctrl_byte[CB_TRIG_A], 2); endproperty
  a_trig: assert property (p_trig) else $error("trigger wrong");
  property p_clear; action.clear_errors == $past(ctrl_valid && ctrl_byte[CB_CLEAR] && !cb_q[CB_CLEAR]); endproperty
  a_clear: assert property (p_clear) else $error("clear pulse wrong");
  property p_restore;
    ctrl_valid && ctrl_byte[CB_RESTORE] && !cb_q[CB_RESTORE] |=>
      action.restore && action.restore_set == $past(ctrl_byte[CB_SET_HI:CB_SET_LO]);
  endproperty
  a_restore: assert property (p_restore) else $error("restore wrong");
  property p_ready; $fell(action.standby) |-> ##[1:RDY_MAX] meas_ready; endproperty
  a_ready: assert property (p_ready) else $error("ready late");
  property p_last; tx_valid && tx_ready |-> tx.last == (bcnt_q == 4'hE); endproperty
  a_last: assert property (p_last) else $error("frame length wrong");
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx); endproperty
  a_hold: assert property (p_hold) else $error("byte changed while stalled");
  property p_net; dhcp_timeout && !dhcp_bound |=> net_addr == FALLBACK_ADDR; endproperty
  a_net: assert property (p_net) else $error("fallback address wrong");
endmodule // fpdm_checker
bind fpdm_mapper fpdm_checker #(.STANDBY_CYC(STANDBY_CYC)) i_chk (.pclk, .presetn, .clk_en, .ctrl_valid,
  .ctrl_byte, .action, .meas_ready, .dhcp_bound, .dhcp_timeout, .net_addr, .tx_valid, .tx_ready, .tx);
`default_nettype wire

// ### fpdm_scanner.sv
`timescale 1ns/1ps
`default_nettype none
module fpdm_scanner
  import fpdm_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic slow, // stall every other cycle
  input wire logic tx_valid, // byte valid
  input wire fpdm_tx_t tx, // byte
  output logic tx_ready, // accept
  output logic [FRAME_BITS-1:0] frame, // last whole frame
  output logic [15:0] nframes // frames seen
);
  logic [FRAME_BITS-1:0] sh_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      sh_q <= '0;
      frame <= '0;
      nframes <= 16'h0000;
    end else begin
      tx_ready <= slow ? !tx_ready : 1'b1;
      if (tx_valid && tx_ready) begin
        sh_q <= {sh_q[FRAME_BITS-9:0], tx.data};
        if (tx.last) begin
          frame <= {sh_q[FRAME_BITS-9:0], tx.data};
          nframes <= nframes + 16'h0001;
        end
      end
    end
  end
endmodule // fpdm_scanner
`default_nettype wire

// ### fpdm_mapper_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fpdm_mapper_tb;
  import fpdm_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sample_valid = 0, ctrl_valid = 0, slow = 0;
  logic clk_en = 1;
  logic dhcp_bound = 1, dhcp_timeout = 0, tx_ready, irq, meas_ready, pready, pslverr, tx_valid, se;
  logic [7:0] paddr = 0, ctrl_byte = 0;
  logic [31:0] pwdata = 0, dhcp_addr = 32'h0A00_0005, prdata, net_addr, rd;
  logic [FRAME_BITS-1:0] frame;
  logic [15:0] nframes;
  logic [1:0] last_set;
  fpdm_sample_t sample = '0;
  fpdm_action_t action;
  fpdm_tx_t tx;
  int num_errors = 0, compares = 0, n_rst = 0, n_clr = 0;
  // standby is left only once its recovery time can run out
  logic [7:0] sb [4] = '{8'h04, 8'h0A, 8'h01, 8'h0F};
  logic [3:0] sx [4] = '{4'b0001, 4'b0110, 4'b1000, 4'b1111};
  logic [7:0] rb [6] = '{8'hC0, 8'hC0, 8'h10, 8'h10, 8'h00, 8'hB0};
  always #20 pclk = ~pclk;
  // pulses counted mid-cycle, away from the edge that launches them
  always @(negedge pclk) begin
    if (action.restore === 1'b1) begin
      n_rst++;
      last_set = action.restore_set;
    end
    if (action.clear_errors === 1'b1) n_clr++;
  end
  fpdm_mapper #(.STANDBY_CYC(20)) i_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq, .sample_valid, .sample, .ctrl_valid, .ctrl_byte, .action,
    .meas_ready, .dhcp_bound, .dhcp_timeout, .dhcp_addr, .net_addr, .tx_valid, .tx_ready, .tx);
  fpdm_scanner i_scan (.pclk, .presetn, .slow, .tx_valid, .tx, .tx_ready, .frame, .nframes);
  task chk(input logic [127:0] seen, input logic [127:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task ctrl(input logic [7:0] b);
    @(posedge pclk);
    ctrl_valid <= 1;
    ctrl_byte <= b;
    @(posedge pclk);
    ctrl_valid <= 0;
    repeat (3) @(posedge pclk);
    #1;
  endtask
  task frm(input fpdm_sample_t s, input logic [FRAME_BITS-1:0] e, input logic sync);
    logic [15:0] k;
    k = nframes;
    @(posedge pclk);
    sample <= s;
    sample_valid <= 1;
    @(posedge pclk);
    sample_valid <= 0;
    if (sync) begin
      repeat (20) @(posedge pclk);
      #1 chk(nframes, k);
      ctrl(8'h08);
    end
    while (nframes === k) begin
      @(posedge pclk);
    end
    #1 chk(frame, e);
  endtask
  task end_sim;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #2000000;
    num_errors++;
    end_sim;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    apb(0, REG_CONFIG, 0);
    chk(rd, 32'(CFG_RESET));
    apb(0, REG_DEVICE_ID, 0);
    chk(rd, DEVICE_ID);
    apb(0, 8'h2C, 0);
    chk({se, rd}, {1'b1, 32'h0});
    chk(net_addr, 32'h0A00_0005);
    dhcp_bound <= 0;
    dhcp_timeout <= 1;
    repeat (3) @(posedge pclk);
    chk(net_addr, 32'hC0A8_0033);
    $display("registers done");
    // negative signs, length past 32 bits
    frm('{33'h1_FFFF_FFFB, 16'h03E8, 48'hFFFE_FFFF_FFEE, 8'h07, 1'b1, 1'b1, 8'h2E},
      120'h0000_00000005_03E8_00000012_07_0F_2E, 1'b0);
    slow <= 1;
    frm('{33'h0_1234_5678, 16'h0000, 48'h0000_8765_4321, 8'h00, 1'b0, 1'b1, 8'h19},
      120'h0001_12345678_0000_87654321_00_02_19, 1'b0);
    slow <= 0;
    apb(0, REG_VELOCITY, 0);
    chk(rd, 32'h1234_5678);
    apb(0, REG_STATE, 0);
    chk(rd, 32'h0000_0102);
    $display("frames done");
    ctrl(8'h04);
    chk({action.standby, meas_ready}, 2'b10);
    ctrl(8'h00);
    chk(meas_ready, 1'b0);
    repeat (25) @(posedge pclk);
    chk(meas_ready, 1'b1);
    apb(1, REG_CONFIG, 32'h3);
    foreach (sb[i]) begin
      ctrl(sb[i]);
      chk(action[7:4], sx[i]);
    end
    apb(1, REG_CONFIG, 32'h2);
    foreach (rb[i]) ctrl(rb[i]);
    chk({n_rst, n_clr, last_set}, {32'd2, 32'd2, 2'h1});
    $display("control done");
    apb(0, REG_IRQ_STATUS, 0);
    chk(rd[IRQ_CONTROL], 1'b1);
    apb(1, REG_IRQ_ENABLE, 32'h4);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    apb(1, REG_IRQ_ENABLE, 32'h0);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    apb(1, REG_IRQ_ENABLE, 32'h4);
    apb(1, REG_IRQ_CLEAR, 32'h3F);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    $display("interrupt done");
    // trigger-synchronous output with the static address selected
    dhcp_bound <= 1;
    apb(1, REG_CONFIG, 32'hE);
    frm('{33'h0_0000_0064, 16'h0001, 48'h0001_0000_0001, 8'h00, 1'b0, 1'b0, 8'h14},
      120'h0002_00000064_0001_00000001_00_00_14, 1'b1);
    chk(net_addr, FALLBACK_ADDR);
    // a frozen block must ignore the control byte strobe
    clk_en <= 0;
    ctrl(8'h00);
    chk(action[7:4], 4'b0010);
    @(posedge pclk);
    clk_en <= 1;
    $display("sync done");
    end_sim;
  end
endmodule // fpdm_mapper_tb
`default_nettype wire
